//--- scmc_map.vh
`ifndef SCMC_MAP_VH
`define SCMC_MAP_VH

// ****************************************************************
// Register offsets (15-bit SPI address space)
// ****************************************************************
`define SCMC_OFS_MOD_CTL      15'h002b
`define SCMC_OFS_LEVEL_CFG    15'h002c
`define SCMC_OFS_BAND_DIV     15'h0030
`define SCMC_OFS_CAL_TMO_LO   15'h0031
`define SCMC_OFS_ADC_TMO_HI   15'h0032
`define SCMC_OFS_RDBK_LOCK    15'h0033
`define SCMC_OFS_FSM_TEST     15'h0034
`define SCMC_OFS_ADC_DIV      15'h0035
`define SCMC_OFS_PUMP_ADJ     15'h0036
`define SCMC_OFS_MAN_BAND     15'h0037
`define SCMC_OFS_MAN_CORE     15'h0038
`define SCMC_OFS_TEST_TUNE    15'h0039
`define SCMC_OFS_ADC_OFFSET   15'h003a
`define SCMC_OFS_PUMP_TEST    15'h003e
`define SCMC_OFS_RDBK_LO      15'h006e
`define SCMC_OFS_RDBK_HI      15'h006f
`define SCMC_OFS_ADC_PWR      15'h0073
`define SCMC_OFS_LOCK_RDBK    15'h007c
`define SCMC_OFS_RF_PWR       15'h0100
`define SCMC_OFS_MIX_EN       15'h0101
`define SCMC_OFS_IF_OVR       15'h0102
`define SCMC_OFS_MIXER_BASE   15'h0100

// ****************************************************************
// Register reset values and the test-tune write mask
// ****************************************************************
`define SCMC_RST_ZERO         8'h00
`define SCMC_RST_RF_PWR       8'h03
`define SCMC_RST_MIX_EN       8'h7f
`define SCMC_RST_IF_OVR       8'h3f
`define SCMC_MASK_TEST_TUNE   8'h7f

// ****************************************************************
// Field codes and timing counts
// ****************************************************************
`define SCMC_RB_CHECKER       3'h0
`define SCMC_RB_CORE_BAND     3'h1
`define SCMC_RB_ADC_TEMP      3'h5
`define SCMC_TM_NORMAL        3'h0
`define SCMC_TM_CORE_BAND     3'h2
`define SCMC_TM_VOLTAGE       3'h4
`define SCMC_CHECKER_WORD     16'h55aa
`define SCMC_TUNE_BASE_MV     12'h244
`define SCMC_TUNE_STEP_MV     12'h096
`define SCMC_LOCK_NOMINAL     14'h0400
`define SCMC_LOCK_SCALE_SHIFT 5
`define SCMC_ADC_DIV_ADD      10'h002
`define SCMC_FRAME_BITS       5'h18
`define SCMC_HEAD_BITS        5'h10
`define SCMC_NUM_RW           18
`define SCMC_IDX_NONE         5'h1f
`define SCMC_IDX_RDBK_LO      5'h12
`define SCMC_IDX_RDBK_HI      5'h13
`define SCMC_IDX_LOCK         5'h14

`endif

//--- scmc_regs.v
`include "scmc_map.vh"
`default_nettype none

module scmc_regs
(
	input  wire         mclk,
	input  wire         arst_n,
	// SPI port, asynchronous to mclk
	input  wire         spi_sclk,
	input  wire         spi_cs_n,
	input  wire         spi_sdi,
	output reg          spi_sdo,
	output reg          spi_sdo_oe,
	// Page select from the page register, same clock
	input  wire [1:0]   page_select,
	// Integer-word register write strobe, same clock
	input  wire         int_word_update,
	// Lock count code from the lock-detect register, same clock
	input  wire [1:0]   lock_count_code,
	// Analog and PLL status, asynchronous
	input  wire         pfd_clk_in,
	input  wire         lock_state_in,
	input  wire         power_down_mode,
	input  wire [5:0]   osc_status_in,
	input  wire [7:0]   cal_band_in,
	input  wire [3:0]   cal_core_in,
	input  wire [7:0]   adc_temp_in,
	// Synthesizer controls
	output reg          modulator_mask_clear,
	output wire         modulator_powerdown,
	output wire         level_loop_off,
	output reg          band_clock_tick,
	output wire [9:0]   cal_timeout,
	output wire [4:0]   lock_wait_count,
	output wire [4:0]   level_loop_wait,
	output wire         adc_input_tune,
	output wire         conv_fast,
	output wire         conv_continuous,
	output wire         conv_single,
	output wire         adc_on,
	output reg          adc_clock_tick,
	output wire [7:0]   pump_current_trim,
	output wire [7:0]   cal_adc_offset,
	output reg          autocal_run,
	output reg          manual_voltage_on,
	output reg  [7:0]   osc_band_applied,
	output reg  [3:0]   osc_core_applied,
	output reg          osc_test_out,
	output wire [3:0]   tune_target_code,
	output reg  [11:0]  tune_target_mv,
	output wire [1:0]   pump_test_select,
	output reg          pump_tristate,
	output wire         feedback_divider_off,
	output reg  [13:0]  lock_cycles,
	// Mixer and IF controls
	output wire         rf_bias_off,
	output wire [2:0]   if_amp_off,
	output wire         mixer_path_select,
	output wire         if_switch_on,
	output wire         mixer_on,
	output reg          if_detector_active,
	output reg          if_gain_loop_active,
	output wire         if_attenuator_on,
	output wire [2:0]   if_amp_on
);

	// ****************************************************************
	// Register indices and decode
	// ****************************************************************
	localparam [4:0] IX_MOD  = 5'h00;
	localparam [4:0] IX_LVL  = 5'h01;
	localparam [4:0] IX_BDIV = 5'h02;
	localparam [4:0] IX_TLO  = 5'h03;
	localparam [4:0] IX_ADC  = 5'h04;
	localparam [4:0] IX_RBK  = 5'h05;
	localparam [4:0] IX_FSM  = 5'h06;
	localparam [4:0] IX_ADIV = 5'h07;
	localparam [4:0] IX_PADJ = 5'h08;
	localparam [4:0] IX_MBND = 5'h09;
	localparam [4:0] IX_MCOR = 5'h0a;
	localparam [4:0] IX_TST  = 5'h0b;
	localparam [4:0] IX_AOFS = 5'h0c;
	localparam [4:0] IX_PTST = 5'h0d;
	localparam [4:0] IX_PWR  = 5'h0e;
	localparam [4:0] IX_RF   = 5'h0f;
	localparam [4:0] IX_MIX  = 5'h10;
	localparam [4:0] IX_IFO  = 5'h11;

	// Address to storage index; unmapped gives the none code
	function [4:0] reg_index;
		input [14:0] a;
		begin
			case (a)
				`SCMC_OFS_MOD_CTL:    reg_index = IX_MOD;
				`SCMC_OFS_LEVEL_CFG:  reg_index = IX_LVL;
				`SCMC_OFS_BAND_DIV:   reg_index = IX_BDIV;
				`SCMC_OFS_CAL_TMO_LO: reg_index = IX_TLO;
				`SCMC_OFS_ADC_TMO_HI: reg_index = IX_ADC;
				`SCMC_OFS_RDBK_LOCK:  reg_index = IX_RBK;
				`SCMC_OFS_FSM_TEST:   reg_index = IX_FSM;
				`SCMC_OFS_ADC_DIV:    reg_index = IX_ADIV;
				`SCMC_OFS_PUMP_ADJ:   reg_index = IX_PADJ;
				`SCMC_OFS_MAN_BAND:   reg_index = IX_MBND;
				`SCMC_OFS_MAN_CORE:   reg_index = IX_MCOR;
				`SCMC_OFS_TEST_TUNE:  reg_index = IX_TST;
				`SCMC_OFS_ADC_OFFSET: reg_index = IX_AOFS;
				`SCMC_OFS_PUMP_TEST:  reg_index = IX_PTST;
				`SCMC_OFS_ADC_PWR:    reg_index = IX_PWR;
				`SCMC_OFS_RF_PWR:     reg_index = IX_RF;
				`SCMC_OFS_MIX_EN:     reg_index = IX_MIX;
				`SCMC_OFS_IF_OVR:     reg_index = IX_IFO;
				`SCMC_OFS_RDBK_LO:    reg_index = `SCMC_IDX_RDBK_LO;
				`SCMC_OFS_RDBK_HI:    reg_index = `SCMC_IDX_RDBK_HI;
				`SCMC_OFS_LOCK_RDBK:  reg_index = `SCMC_IDX_LOCK;
				default:              reg_index = `SCMC_IDX_NONE;
			endcase
		end
	endfunction

	// Reset value of each stored register
	function [7:0] reset_value;
		input [4:0] ix;
		begin
			case (ix)
				IX_RF:   reset_value = `SCMC_RST_RF_PWR;
				IX_MIX:  reset_value = `SCMC_RST_MIX_EN;
				IX_IFO:  reset_value = `SCMC_RST_IF_OVR;
				default: reset_value = `SCMC_RST_ZERO;
			endcase
		end
	endfunction

	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	localparam SYNC_W = 12;
	wire [SYNC_W-1:0] async_in;
	wire [SYNC_W-1:0] sync_w;

	assign async_in = {osc_status_in, power_down_mode, lock_state_in, pfd_clk_in,
	                   spi_sdi, spi_cs_n, spi_sclk};

	// Two flops per pin; the first stage feeds only the second. The select
	// line resets to its idle high level so no frame seems open after reset
	genvar g;
	generate
		for (g = 0; g < SYNC_W; g = g + 1)
		begin : g_sync
			reg meta_r;
			reg sync_r;
			always @(posedge mclk or negedge arst_n)
			begin
				if (!arst_n)
				begin
					meta_r <= (g == 1);
					sync_r <= (g == 1);
				end
				else
				begin
					meta_r <= async_in[g];
					sync_r <= meta_r;
				end
			end
			assign sync_w[g] = sync_r;
		end
	endgenerate

	wire       sclk_s  = sync_w[0];
	wire       cs_n_s  = sync_w[1];
	wire       sdi_s   = sync_w[2];
	wire       pfd_s   = sync_w[3];
	wire       lock_s  = sync_w[4];
	wire       pdm_s   = sync_w[5];
	wire [5:0] stat_s  = sync_w[11:6];

	reg sclk_d_r;
	reg pfd_d_r;
	wire sclk_rise = sclk_s & ~sclk_d_r;
	wire sclk_fall = ~sclk_s & sclk_d_r;
	wire pfd_rise  = pfd_s & ~pfd_d_r;

	// ****************************************************************
	// Register storage
	// ****************************************************************
	reg  [7:0]  mem_r [0:`SCMC_NUM_RW-1];
	reg  [15:0] rdbk_r;
	reg  [4:0]  bit_cnt_r;
	reg  [23:0] shift_in_r;
	reg  [7:0]  shift_out_r;
	reg         read_op_r;
	wire [23:0] frame_now = {shift_in_r[22:0], sdi_s};
	wire [4:0]  wr_ix     = reg_index(frame_now[22:8]);
	wire [14:0] hdr_addr  = frame_now[14:0];
	wire        last_bit  = sclk_rise && (bit_cnt_r == `SCMC_FRAME_BITS - 5'h01);
	wire        head_done = sclk_rise && (bit_cnt_r == `SCMC_HEAD_BITS - 5'h01);
	integer i;

	// Read data for an address, honouring the page in force
	reg  [7:0] rd_data;
	wire [4:0] rd_ix = reg_index(hdr_addr);
	always @*
	begin
		if (rd_ix == `SCMC_IDX_RDBK_LO)
			rd_data = rdbk_r[7:0];
		else if (rd_ix == `SCMC_IDX_RDBK_HI)
			rd_data = rdbk_r[15:8];
		else if (rd_ix == `SCMC_IDX_LOCK)
			rd_data = {7'h00, lock_s};
		else if (rd_ix < `SCMC_NUM_RW)
			rd_data = mem_r[rd_ix];
		else
			rd_data = 8'h00;
		// Wrong page reads as zero
		if ((hdr_addr >= `SCMC_OFS_MIXER_BASE) != (page_select == 2'h1))
			rd_data = 8'h00;
	end

	// Frame engine: R/W bit, 15-bit address, 8 data bits, MSB first
	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sclk_d_r    <= 1'b0;
			pfd_d_r     <= 1'b0;
			bit_cnt_r   <= 5'h00;
			shift_in_r  <= 24'h000000;
			shift_out_r <= 8'h00;
			read_op_r   <= 1'b0;
			spi_sdo     <= 1'b0;
			spi_sdo_oe  <= 1'b0;
			for (i = 0; i < `SCMC_NUM_RW; i = i + 1)
				mem_r[i] <= reset_value(i[4:0]);
		end
		else
		begin
			sclk_d_r <= sclk_s;
			pfd_d_r  <= pfd_s;
			if (cs_n_s)
			begin
				// Deselect aborts any partial frame
				bit_cnt_r  <= 5'h00;
				read_op_r  <= 1'b0;
				spi_sdo_oe <= 1'b0;
			end
			else
			begin
				if (sclk_rise)
				begin
					shift_in_r <= frame_now;
					bit_cnt_r  <= last_bit ? 5'h00 : bit_cnt_r + 5'h01;
				end
				if (head_done)
				begin
					read_op_r   <= frame_now[15];
					shift_out_r <= rd_data;
				end
				if (sclk_fall && read_op_r)
				begin
					spi_sdo     <= shift_out_r[7];
					shift_out_r <= {shift_out_r[6:0], 1'b0};
					spi_sdo_oe  <= 1'b1;
				end
				if (last_bit)
					read_op_r <= 1'b0;
				// Read-only addresses fall outside the stored range
				if (last_bit && !frame_now[23] && wr_ix < `SCMC_NUM_RW)
				begin
					if (wr_ix == IX_TST)
						mem_r[wr_ix] <= frame_now[7:0] & `SCMC_MASK_TEST_TUNE;
					else
						mem_r[wr_ix] <= frame_now[7:0];
				end
			end
		end
	end

	// ****************************************************************
	// Field outputs straight from the stored bytes
	// ****************************************************************
	assign modulator_powerdown  = mem_r[IX_MOD][0];
	assign level_loop_off       = mem_r[IX_LVL][0];
	assign cal_timeout          = {mem_r[IX_ADC][1:0], mem_r[IX_TLO]};
	assign lock_wait_count      = mem_r[IX_RBK][4:0];
	assign level_loop_wait      = mem_r[IX_FSM][4:0];
	assign adc_input_tune       = mem_r[IX_ADC][7];
	assign conv_fast            = mem_r[IX_ADC][5];
	assign conv_continuous      = mem_r[IX_ADC][4];
	assign conv_single          = mem_r[IX_ADC][3];
	assign adc_on               = mem_r[IX_ADC][2];
	assign pump_current_trim    = mem_r[IX_PADJ];
	assign cal_adc_offset       = mem_r[IX_AOFS];
	assign tune_target_code     = mem_r[IX_TST][3:0];
	assign pump_test_select     = mem_r[IX_PTST][3:2];
	assign feedback_divider_off = mem_r[IX_PWR][1];
	assign rf_bias_off          = mem_r[IX_RF][7];
	assign if_amp_off           = mem_r[IX_RF][5:3];
	assign mixer_path_select    = mem_r[IX_RF][1];
	assign if_switch_on         = mem_r[IX_RF][0];
	assign mixer_on             = mem_r[IX_MIX][3];
	assign if_attenuator_on     = mem_r[IX_IFO][5];
	assign if_amp_on            = mem_r[IX_IFO][3:1];

	// ****************************************************************
	// Clock dividers on the phase-detector rate
	// ****************************************************************
	reg  [7:0] band_cnt_r;
	reg  [9:0] adc_cnt_r;
	wire [7:0] band_div   = (mem_r[IX_BDIV] == 8'h00) ? 8'h01 : mem_r[IX_BDIV];
	wire [9:0] adc_period = {mem_r[IX_ADIV], 2'b00} + `SCMC_ADC_DIV_ADD;
	// ADC enable overrides the clock-disable bit
	wire       adc_clk_run = adc_on | ~mem_r[IX_PWR][2];

	// Divider only sees the phase-detector edge after synchronising, so it
	// is exact only while that rate sits well below half of mclk
	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			band_cnt_r      <= 8'h00;
			adc_cnt_r       <= 10'h000;
			band_clock_tick <= 1'b0;
			adc_clock_tick  <= 1'b0;
		end
		else
		begin
			band_clock_tick <= 1'b0;
			adc_clock_tick  <= 1'b0;
			if (pfd_rise)
			begin
				if (band_cnt_r + 8'h01 >= band_div)
				begin
					band_cnt_r      <= 8'h00;
					band_clock_tick <= 1'b1;
				end
				else
					band_cnt_r <= band_cnt_r + 8'h01;
			end
			if (!adc_clk_run)
				adc_cnt_r <= 10'h000;
			else if (pfd_rise)
			begin
				if (adc_cnt_r + 10'h001 >= adc_period)
				begin
					adc_cnt_r      <= 10'h000;
					adc_clock_tick <= 1'b1;
				end
				else
					adc_cnt_r <= adc_cnt_r + 10'h001;
			end
		end
	end

	// ****************************************************************
	// Derived controls, readback and test routing
	// ****************************************************************
	wire [2:0] test_mode  = mem_r[IX_FSM][7:5];
	wire [2:0] rb_select  = mem_r[IX_RBK][7:5];
	wire [2:0] test_route = mem_r[IX_TST][6:4];
	wire       manual_cb  = (test_mode == `SCMC_TM_CORE_BAND);
	reg  [15:0] rdbk_nxt;
	reg         test_nxt;

	// Readback word selection
	always @*
	begin
		case (rb_select)
			`SCMC_RB_CHECKER:   rdbk_nxt = `SCMC_CHECKER_WORD;
			`SCMC_RB_CORE_BAND: rdbk_nxt = {4'h0, osc_core_applied, osc_band_applied};
			`SCMC_RB_ADC_TEMP:  rdbk_nxt = {8'h00, adc_temp_in};
			default:            rdbk_nxt = 16'h0000;
		endcase
	end

	// Test signal route; codes 3 and 7 drive low
	always @*
	begin
		case (test_route)
			3'h0:    test_nxt = stat_s[0];
			3'h1:    test_nxt = stat_s[1];
			3'h2:    test_nxt = stat_s[2];
			3'h4:    test_nxt = stat_s[3];
			3'h5:    test_nxt = stat_s[4];
			3'h6:    test_nxt = stat_s[5];
			default: test_nxt = 1'b0;
		endcase
	end

	// All derived outputs registered so every port leaves a flop
	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rdbk_r               <= 16'h0000;
			osc_test_out         <= 1'b0;
			modulator_mask_clear <= 1'b0;
			autocal_run          <= 1'b0;
			manual_voltage_on    <= 1'b0;
			osc_band_applied     <= 8'h00;
			osc_core_applied     <= 4'h0;
			tune_target_mv       <= 12'h000;
			pump_tristate        <= 1'b0;
			lock_cycles          <= 14'h0000;
			if_detector_active   <= 1'b0;
			if_gain_loop_active  <= 1'b0;
		end
		else
		begin
			rdbk_r               <= rdbk_nxt;
			osc_test_out         <= test_nxt;
			modulator_mask_clear <= int_word_update & mem_r[IX_MOD][2];
			autocal_run          <= (test_mode == `SCMC_TM_NORMAL);
			manual_voltage_on    <= (test_mode == `SCMC_TM_VOLTAGE);
			osc_band_applied     <= manual_cb ? mem_r[IX_MBND] : cal_band_in;
			osc_core_applied     <= manual_cb ? mem_r[IX_MCOR][7:4] : cal_core_in;
			tune_target_mv       <= `SCMC_TUNE_BASE_MV
			                        + `SCMC_TUNE_STEP_MV * {8'h00, tune_target_code};
			pump_tristate        <= (pump_test_select == 2'h0);
			lock_cycles          <= mem_r[IX_PWR][0]
			                        ? ((`SCMC_LOCK_NOMINAL << lock_count_code)
			                           >> `SCMC_LOCK_SCALE_SHIFT)
			                        : (`SCMC_LOCK_NOMINAL << lock_count_code);
			// Detector and gain loop, while their mixer-register enable bits are set, run when forced, else in power-down only
			if_detector_active   <= mem_r[IX_MIX][2] & (mem_r[IX_IFO][7] | pdm_s);
			if_gain_loop_active  <= mem_r[IX_MIX][0] & (mem_r[IX_IFO][6] | pdm_s);
		end
	end

endmodule // scmc_regs

`default_nettype wire

//--- scmc_regs_chk.sv
`default_nettype none
module scmc_regs_chk
(
	input wire logic        mclk,
	input wire logic        arst_n,
	input wire logic        int_word_update,
	input wire logic [1:0]  lock_count_code,
	input wire logic [7:0]  cal_band_in,
	input wire logic [3:0]  cal_core_in,
	input wire logic        modulator_mask_clear,
	input wire logic        band_clock_tick,
	input wire logic        adc_clock_tick,
	input wire logic        autocal_run,
	input wire logic        manual_voltage_on,
	input wire logic [7:0]  osc_band_applied,
	input wire logic [3:0]  osc_core_applied,
	input wire logic [3:0]  tune_target_code,
	input wire logic [11:0] tune_target_mv,
	input wire logic [1:0]  pump_test_select,
	input wire logic        pump_tristate,
	input wire logic [13:0] lock_cycles
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// Port relations, all in the mclk domain
	// ****************************************
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!arst_n);
	// Mask clear only ever follows an integer-word update by one cycle
	AST_MASK_CAUSE: assert property (modulator_mask_clear |-> $past(int_word_update))
		else $error("mask clear without integer-word update");
	AST_TUNE_MV: assert property (1 |=>
		tune_target_mv == 12'h244 + 12'h096 * $past(tune_target_code))
		else $error("tuning target voltage does not match code");
	AST_PUMP_TRI: assert property (1 |=> pump_tristate == ($past(pump_test_select) == 2'h0))
		else $error("pump tristate does not follow test field");
	// Scale bit is internal, so either the nominal or the divided count is legal
	AST_LOCK_COUNT: assert property (1 |=>
		(lock_cycles == (14'h0400 << $past(lock_count_code)))
		|| (lock_cycles == ((14'h0400 << $past(lock_count_code)) >> 5)))
		else $error("lock cycle count is neither nominal nor divided");
	AST_MODE_EXCL: assert property (!(autocal_run && manual_voltage_on))
		else $error("two test modes active at once");
	AST_AUTO_APPLY: assert property (autocal_run |->
		osc_band_applied == $past(cal_band_in) && osc_core_applied == $past(cal_core_in))
		else $error("autocal mode does not apply calibration results");
	AST_BAND_PULSE: assert property (band_clock_tick |=> !band_clock_tick)
		else $error("band clock tick longer than one cycle");
	// Smallest divide is two phase-detector edges, each more than four mclk apart
	AST_ADC_SPACING: assert property (adc_clock_tick |=> !adc_clock_tick [*8])
		else $error("adc clock ticks too close together");
endmodule // scmc_regs_chk

bind scmc_regs scmc_regs_chk u_chk (.mclk, .arst_n, .int_word_update, .lock_count_code,
	.cal_band_in, .cal_core_in, .modulator_mask_clear, .band_clock_tick, .adc_clock_tick,
	.autocal_run, .manual_voltage_on, .osc_band_applied, .osc_core_applied,
	.tune_target_code, .tune_target_mv, .pump_test_select, .pump_tristate, .lock_cycles);
`default_nettype wire

//--- scmc_spi_host.sv
`default_nettype none
module scmc_spi_host
(
	input  wire logic mclk,
	output var  logic spi_sclk,
	output var  logic spi_cs_n,
	output var  logic spi_sdi,
	input  wire logic spi_sdo,
	input  wire logic spi_sdo_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle bus: clock stands low, select high
	initial
	begin
		spi_sclk = 1'b0;
		spi_cs_n = 1'b1;
		spi_sdi = 1'b0;
	end
	// Five mclk per half period, above the four the synchroniser needs
	task automatic half();
		repeat (5) @(negedge mclk);
	endtask
	// One 24-bit frame MSB first; read bits are taken on rises 17 to 24
	task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] d,
		output logic [7:0] q);
		logic [23:0] f;
		f = {rd, a, d};
		spi_cs_n = 1'b0;
		for (int i = 23; i >= 0; i--)
		begin
			spi_sdi = f[i];
			half();
			spi_sclk = 1'b1;
			if (i < 8)
				q[i] = spi_sdo_oe ? spi_sdo : 1'bx;
			half();
			spi_sclk = 1'b0;
		end
		half();
		spi_cs_n = 1'b1;
		spi_sdi = ~f[0];  // Released data line must not keep the last bit
		half();
	endtask
endmodule // scmc_spi_host
`default_nettype wire

//--- tb_scmc_regs.sv
`default_nettype none
module tb_scmc_regs;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk, arst_n, int_word_update, lock_state_in, power_down_mode;
	logic [1:0]  page_select, lock_count_code;
	logic [2:0]  pfd_cnt;
	wire         pfd_clk_in, spi_sclk, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe;
	wire         modulator_mask_clear, modulator_powerdown, level_loop_off, band_clock_tick;
	wire         adc_input_tune, conv_fast, conv_continuous, conv_single, adc_on;
	wire         adc_clock_tick, autocal_run, manual_voltage_on, osc_test_out, pump_tristate;
	wire         mixer_on, if_detector_active;
	wire [9:0]   cal_timeout;
	wire [7:0]   osc_band_applied;
	wire [3:0]   osc_core_applied;
	wire [11:0]  tune_target_mv;
	wire [13:0]  lock_cycles;
	wire [7:0]   pump_current_trim, cal_adc_offset;
	wire [4:0]   lock_wait_count, level_loop_wait;
	wire [2:0]   if_amp_off, if_amp_on;
	wire         feedback_divider_off, rf_bias_off, mixer_path_select, if_switch_on;
	wire         if_gain_loop_active, if_attenuator_on;
	logic [5:0]  osc_status;
	int          err_count, checks, nb, na, nm;

	scmc_spi_host u_host (.mclk, .spi_sclk, .spi_cs_n, .spi_sdi, .spi_sdo, .spi_sdo_oe);
	scmc_regs uut (.mclk, .arst_n, .spi_sclk, .spi_cs_n, .spi_sdi, .spi_sdo, .spi_sdo_oe,
		.page_select, .int_word_update, .lock_count_code, .pfd_clk_in, .lock_state_in,
		.power_down_mode, .osc_status_in(osc_status), .cal_band_in(8'h3c), .cal_core_in(4'h9),
		.adc_temp_in(8'h71), .modulator_mask_clear, .modulator_powerdown, .level_loop_off,
		.band_clock_tick, .cal_timeout, .lock_wait_count, .level_loop_wait,
		.adc_input_tune, .conv_fast, .conv_continuous, .conv_single, .adc_on, .adc_clock_tick,
		.pump_current_trim, .cal_adc_offset, .autocal_run, .manual_voltage_on,
		.osc_band_applied, .osc_core_applied, .osc_test_out, .tune_target_code(),
		.tune_target_mv, .pump_test_select(), .pump_tristate, .feedback_divider_off,
		.lock_cycles, .rf_bias_off, .if_amp_off, .mixer_path_select, .if_switch_on,
		.mixer_on, .if_detector_active, .if_gain_loop_active, .if_attenuator_on,
		.if_amp_on);

	// ****************************************
	// Clock, phase-detector clock and helpers
	// ****************************************
	initial
	begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	// Phase detector runs at an eighth of mclk, inside the sampling limit
	always @(negedge mclk)
		pfd_cnt <= pfd_cnt + 3'h1;
	assign pfd_clk_in = pfd_cnt[2];

	task automatic stop_test();
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [14:0] a, input logic [7:0] d);
		logic [7:0] q;
		u_host.xfer(1'b0, a, d, q);
	endtask
	// Read on a chosen page and compare
	task automatic rc(input logic [14:0] a, input logic pg, input logic [7:0] exp);
		logic [7:0] q;
		page_select = {1'b0, pg};
		u_host.xfer(1'b1, a, 8'h00, q);
		chk(16'(q), 16'(exp));
	endtask
	// Count pulses over a window; sampled just after the edge so flops have settled.
	// A raised integer-word strobe drops at the first falling edge, one cycle wide
	task automatic cnt(input int n);
		nb = 0;
		na = 0;
		nm = 0;
		repeat (n)
		begin
			@(posedge mclk);
			#1;
			nb += int'(band_clock_tick);
			na += int'(adc_clock_tick);
			nm += int'(modulator_mask_clear);
			@(negedge mclk);
			int_word_update = 1'b0;
		end
	endtask

	// Hang guard
	initial
	begin
		repeat (100000) @(posedge mclk);
		err_count++;
		stop_test();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		arst_n = 1'b0;
		int_word_update = 1'b0;
		lock_state_in = 1'b1;
		power_down_mode = 1'b0;
		osc_status = 6'h1d;
		page_select = 2'h0;
		lock_count_code = 2'h3;
		pfd_cnt = 3'h0;
		err_count = 0;
		checks = 0;
		repeat (20) @(negedge mclk);
		arst_n = 1'b1;
		repeat (3) @(negedge mclk);
		chk(16'(mixer_on), 16'h0001);
		chk(16'({if_attenuator_on, if_amp_on}), 16'h000f);
		chk(16'(if_gain_loop_active), 16'h0000);
		chk(16'(pump_tristate), 16'h0001);
		chk(16'(if_detector_active), 16'h0000);
		chk(16'(autocal_run), 16'h0001);
		rc(15'h0100, 1'b1, 8'h03);
		rc(15'h0101, 1'b1, 8'h7f);
		rc(15'h0102, 1'b1, 8'h3f);
		rc(15'h006e, 1'b0, 8'haa);
		rc(15'h006f, 1'b0, 8'h55);
		wr(15'h006e, 8'h00);
		rc(15'h006e, 1'b0, 8'haa);
		rc(15'h007c, 1'b0, 8'h01);
		rc(15'h007c, 1'b1, 8'h00);
		rc(15'h0040, 1'b0, 8'h00);
		wr(15'h0033, 8'h20);
		rc(15'h006e, 1'b0, 8'h3c);
		rc(15'h006f, 1'b0, 8'h09);
		wr(15'h0033, 8'hb3);
		chk(16'(lock_wait_count), 16'h0013);
		rc(15'h006e, 1'b0, 8'h71);
		wr(15'h0031, 8'h5a);
		wr(15'h0032, 8'hfa);
		chk(16'(cal_timeout), 16'h025a);
		chk(16'(adc_input_tune), 16'h0001);
		chk(16'({conv_fast, conv_continuous, conv_single, adc_on}), 16'h000e);
		rc(15'h0032, 1'b0, 8'hfa);
		wr(15'h002c, 8'h01);
		chk(16'(level_loop_off), 16'h0001);
		wr(15'h0039, 8'hff);
		rc(15'h0039, 1'b0, 8'h7f);
		chk(16'(osc_test_out), 16'h0000);
		for (int k = 0; k < 16; k++)
		begin
			wr(15'h0039, 8'(k));
			chk(16'(tune_target_mv), 16'(12'h244 + 12'h096 * k));
		end
		chk(16'(osc_test_out), 16'h0001);
		// Route codes 0 to 6 against the status pattern, then code 6 with the pattern flipped
		for (int r = 0; r < 7; r++)
		begin
			wr(15'h0039, 8'(r << 4));
			chk(16'(osc_test_out), 16'(r == 3 ? 1'b0 : osc_status[r - int'(r > 3)]));
		end
		osc_status = 6'h22;
		repeat (4) @(negedge mclk);
		chk(16'(osc_test_out), 16'h0001);
		wr(15'h0036, 8'h30);
		wr(15'h003a, 8'h81);
		chk(16'({pump_current_trim, cal_adc_offset}), 16'h3081);
		// Mask clear follows the update only while enabled
		wr(15'h002b, 8'h04);
		int_word_update = 1'b1;
		cnt(4);
		chk(16'(nm), 16'h0001);
		wr(15'h002b, 8'h01);
		chk(16'(modulator_powerdown), 16'h0001);
		int_word_update = 1'b1;
		cnt(4);
		chk(16'(nm), 16'h0000);
		// Dividers: band 3 gives 24 mclk, adc 4*1+2 gives 48 mclk
		wr(15'h0030, 8'h03);
		wr(15'h0035, 8'h01);
		wr(15'h0032, 8'h00);
		wr(15'h0073, 8'h04);
		cnt(480);
		chk(16'(nb), 16'h0014);
		chk(16'(na), 16'h0000);
		wr(15'h0032, 8'h04);
		cnt(100);
		cnt(480);
		chk(16'(na), 16'h000a);
		wr(15'h0073, 8'h07);
		chk(16'(lock_cycles), 16'h0100);
		chk(16'(feedback_divider_off), 16'h0001);
		// Manual core and band override, then manual voltage mode
		wr(15'h0037, 8'ha5);
		wr(15'h0038, 8'hc3);
		wr(15'h0034, 8'h40);
		chk(16'({osc_core_applied, osc_band_applied}), 16'h0ca5);
		chk(16'({autocal_run, manual_voltage_on}), 16'h0000);
		rc(15'h0038, 1'b0, 8'hc3);
		wr(15'h0034, 8'h9f);
		chk(16'(manual_voltage_on), 16'h0001);
		chk(16'(level_loop_wait), 16'h001f);
		wr(15'h003e, 8'h0c);
		chk(16'(pump_tristate), 16'h0000);
		wr(15'h0100, 8'hab);
		chk(16'({rf_bias_off, if_amp_off, mixer_path_select, if_switch_on}), 16'h0037);
		wr(15'h0102, 8'hbf);
		chk(16'(if_detector_active), 16'h0001);
		chk(16'(if_gain_loop_active), 16'h0000);
		wr(15'h0102, 8'h3f);
		power_down_mode = 1'b1;
		repeat (5) @(negedge mclk);
		chk(16'(if_detector_active), 16'h0001);
		chk(16'(if_gain_loop_active), 16'h0001);
		stop_test();
	end
endmodule // tb_scmc_regs
`default_nettype wire
